/* File: core/pcivr_regs.sv */
// pcivr_regs.sv: pci configuration base, misc and target image 0 registers
// assumes: one register access per cycle on the config port, pci clock only
//
// Function
// - writable 4 KB base field, resets zero
// - bit 0 is read-only space indicator
// - address line strap picks base spaces
// - second space bit inverts the first
// - image registers locked until base written
// - memory base anywhere in 32 bits
// - minimum grant reads three
// - interrupt pin reads one
// - maximum latency reads zero
// - interrupt line stores writes only
// - width field codes, resets 32-bit
// - address space codes, strap reset
// - block transfer bit, resets zero
// - block bit needs A24/A32, narrow width
// - A24/A32 with 64-bit allows multiplexed blocks
// - io space forces coupled transfers
// - pci space bit selects memory/io
// - enable bit turns decoding on
// - image claims base to bound, or base to top when bound is zero
// - vme address adds translation offset
`timescale 1ns/10ps
`include "pcivr_params.svh"
module pcivr_regs (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_strap_va1,
   input wire logic i_strap_img_en,
   input wire logic i_strap_img_las,
   input wire logic [2:0] i_strap_img_vas,
   input wire logic [3:0] i_strap_img_top,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [11:0] i_reg_addr,
   input wire logic [3:0] i_reg_be,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_pci_valid,
   input wire logic i_pci_io,
   input wire logic [31:0] i_pci_addr,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_ack,
   output logic o_regs_open,
   output logic o_win_hit,
   output logic o_image_hit,
   output logic [31:0] o_vme_addr,
   output pcivr_pkg::pcivr_width_e o_vme_width,
   output pcivr_pkg::pcivr_space_e o_vme_space,
   output logic o_block_xfer,
   output logic o_mblt_allowed,
   output logic o_posted_write,
   output logic o_am_program,
   output logic o_am_super
);
   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   logic s_load;
   logic [9:0] s_pins;
   pcivr_strap u_strap (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_pins({i_strap_img_top, i_strap_img_vas, i_strap_img_las, i_strap_img_en, i_strap_va1}),
      .o_load(s_load),
      .o_pins(s_pins)
   );
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   pcivr_pkg::pcivr_page_t bs0_r, bs0_nxt, bs1_r, bs1_nxt;
   pcivr_pkg::pcivr_page_t lbs_r, lbs_nxt, lbd_r, lbd_nxt, lto_r, lto_nxt;
   pcivr_pkg::pcivr_width_e vdw_r, vdw_nxt;
   pcivr_pkg::pcivr_space_e vas_r, vas_nxt;
   logic space0_r, space0_nxt, open_r, open_nxt;
   logic en_r, en_nxt, posted_write_enable_r, posted_write_enable_nxt, pgm_r, pgm_nxt;
   logic super_r, super_nxt, vct_r, vct_nxt, las_r, las_nxt;
   logic [7:0] int_line_r, int_line_nxt;
   logic [31:0] ctl_word, bs0_word, bs1_word, misc_word, m;
   logic [11:0] waddr;
   logic dev_ok;
   function automatic logic [31:0] pcivr_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) res[i*8 +: 8] = wd[i*8 +: 8];
      end
      return res;
   endfunction : pcivr_merge
   always_comb begin
      waddr = {i_reg_addr[11:2], 2'h0};
      dev_ok = open_r | (waddr < `PCIVR_DEV_FIRST);
      bs0_word = {bs0_r, 11'h000, space0_r};
      bs1_word = {bs1_r, 11'h000, ~space0_r};
      misc_word = {`PCIVR_MAX_LATENCY_FIELD, `PCIVR_MIN_GNT, `PCIVR_INT_PIN, int_line_r};
      ctl_word = `PCIVR_WORD_ZERO;
      ctl_word[`PCIVR_CTL_EN] = en_r;
      ctl_word[`PCIVR_CTL_POSTED_WRITE_ENABLE] = posted_write_enable_r;
      ctl_word[`PCIVR_CTL_VDW_LSB +: 2] = vdw_r;
      ctl_word[`PCIVR_CTL_VAS_LSB +: 3] = vas_r;
      ctl_word[`PCIVR_CTL_PGM] = pgm_r;
      ctl_word[`PCIVR_CTL_SUPER] = super_r;
      ctl_word[`PCIVR_CTL_VCT] = vct_r;
      ctl_word[`PCIVR_CTL_LAS] = las_r;
      bs0_nxt = bs0_r;
      bs1_nxt = bs1_r;
      space0_nxt = space0_r;
      open_nxt = open_r;
      int_line_nxt = int_line_r;
      en_nxt = en_r;
      posted_write_enable_nxt = posted_write_enable_r;
      vdw_nxt = vdw_r;
      vas_nxt = vas_r;
      pgm_nxt = pgm_r;
      super_nxt = super_r;
      vct_nxt = vct_r;
      las_nxt = las_r;
      lbs_nxt = lbs_r;
      lbd_nxt = lbd_r;
      lto_nxt = lto_r;
      m = `PCIVR_WORD_ZERO;
      if (s_load) begin
         space0_nxt = ~s_pins[0];
         en_nxt = s_pins[1];
         las_nxt = s_pins[2];
         vas_nxt = pcivr_pkg::pcivr_space_e'(s_pins[5:3]);
         lbs_nxt = {s_pins[9:6], `PCIVR_MID_RST};
         lbd_nxt = {s_pins[9:6], `PCIVR_MID_RST};
      end else if (i_reg_wr && dev_ok) begin
         unique case (waddr)
            `PCIVR_OFF_BS0: begin
               m = pcivr_merge(bs0_word, i_reg_wdata, i_reg_be);
               bs0_nxt = m[31:`PCIVR_BASE_LSB];
               open_nxt = 1'b1;
            end
            `PCIVR_OFF_BS1: begin
               m = pcivr_merge(bs1_word, i_reg_wdata, i_reg_be);
               bs1_nxt = m[31:`PCIVR_BASE_LSB];
               open_nxt = 1'b1;
            end
            `PCIVR_OFF_MISC1: begin
               m = pcivr_merge(misc_word, i_reg_wdata, i_reg_be);
               int_line_nxt = m[7:0];
            end
            `PCIVR_OFF_CTL: begin
               m = pcivr_merge(ctl_word, i_reg_wdata, i_reg_be);
               en_nxt = m[`PCIVR_CTL_EN];
               posted_write_enable_nxt = m[`PCIVR_CTL_POSTED_WRITE_ENABLE];
               vdw_nxt = pcivr_pkg::pcivr_width_e'(m[`PCIVR_CTL_VDW_LSB +: 2]);
               vas_nxt = pcivr_pkg::pcivr_space_e'(m[`PCIVR_CTL_VAS_LSB +: 3]);
               pgm_nxt = m[`PCIVR_CTL_PGM];
               super_nxt = m[`PCIVR_CTL_SUPER];
               vct_nxt = m[`PCIVR_CTL_VCT];
               las_nxt = m[`PCIVR_CTL_LAS];
            end
            `PCIVR_OFF_LBS: begin
               m = pcivr_merge({lbs_r, 12'h000}, i_reg_wdata, i_reg_be);
               lbs_nxt = m[31:`PCIVR_BASE_LSB];
            end
            `PCIVR_OFF_LBD: begin
               m = pcivr_merge({lbd_r, 12'h000}, i_reg_wdata, i_reg_be);
               lbd_nxt = m[31:`PCIVR_BASE_LSB];
            end
            `PCIVR_OFF_LTO: begin
               m = pcivr_merge({lto_r, 12'h000}, i_reg_wdata, i_reg_be);
               lto_nxt = m[31:`PCIVR_BASE_LSB];
            end
            default: m = `PCIVR_WORD_ZERO;
         endcase
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         bs0_r <= `PCIVR_BASE_RST;
         bs1_r <= `PCIVR_BASE_RST;
         space0_r <= 1'b0;
         open_r <= 1'b0;
         int_line_r <= `PCIVR_INT_LINE_RST;
         en_r <= 1'b0;
         posted_write_enable_r <= 1'b0;
         vdw_r <= pcivr_pkg::PCIVR_W32;
         vas_r <= pcivr_pkg::PCIVR_A16;
         pgm_r <= 1'b0;
         super_r <= 1'b0;
         vct_r <= 1'b0;
         las_r <= 1'b0;
         lbs_r <= `PCIVR_BASE_RST;
         lbd_r <= `PCIVR_BASE_RST;
         lto_r <= `PCIVR_BASE_RST;
      end else begin
         bs0_r <= bs0_nxt;
         bs1_r <= bs1_nxt;
         space0_r <= space0_nxt;
         open_r <= open_nxt;
         int_line_r <= int_line_nxt;
         en_r <= en_nxt;
         posted_write_enable_r <= posted_write_enable_nxt;
         vdw_r <= vdw_nxt;
         vas_r <= vas_nxt;
         pgm_r <= pgm_nxt;
         super_r <= super_nxt;
         vct_r <= vct_nxt;
         las_r <= las_nxt;
         lbs_r <= lbs_nxt;
         lbd_r <= lbd_nxt;
         lto_r <= lto_nxt;
      end
   end
   // ---------------------------------------------------------------
   // read answer and image outputs
   // ---------------------------------------------------------------
   logic dec_hit;
   logic [31:0] dec_vme;
   logic [31:0] rdata_r, rdata_nxt, vme_r;
   logic ack_r, hit_r, win_r, win_nxt, blt_r, blt_nxt, mblt_r, mblt_nxt, pw_r, pw_nxt;
   logic wide_space;
   pcivr_img_dec u_img0 (
      .i_valid(i_pci_valid),
      .i_io(i_pci_io),
      .i_addr(i_pci_addr),
      .i_enable(en_r),
      .i_las(las_r),
      .i_base(lbs_r),
      .i_bound(lbd_r),
      .i_offset(lto_r),
      .o_hit(dec_hit),
      .o_vme_addr(dec_vme)
   );
   always_comb begin
      rdata_nxt = `PCIVR_WORD_ZERO;
      if (i_reg_rd && dev_ok) begin
         unique case (waddr)
            `PCIVR_OFF_BS0: rdata_nxt = bs0_word;
            `PCIVR_OFF_BS1: rdata_nxt = bs1_word;
            `PCIVR_OFF_MISC1: rdata_nxt = misc_word;
            `PCIVR_OFF_CTL: rdata_nxt = ctl_word;
            `PCIVR_OFF_LBS: rdata_nxt = {lbs_r, 12'h000};
            `PCIVR_OFF_LBD: rdata_nxt = {lbd_r, 12'h000};
            `PCIVR_OFF_LTO: rdata_nxt = {lto_r, 12'h000};
            default: rdata_nxt = `PCIVR_WORD_ZERO;
         endcase
      end
      wide_space = (vas_r == pcivr_pkg::PCIVR_A24) | (vas_r == pcivr_pkg::PCIVR_A32);
      blt_nxt = vct_r & wide_space & (vdw_r != pcivr_pkg::PCIVR_W64);
      mblt_nxt = wide_space & (vdw_r == pcivr_pkg::PCIVR_W64);
      pw_nxt = posted_write_enable_r & ~las_r;
      win_nxt = i_pci_valid & (((i_pci_addr[31:12] == bs0_r) & (i_pci_io == space0_r)) |
                               ((i_pci_addr[31:12] == bs1_r) & (i_pci_io == ~space0_r)));
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rdata_r <= `PCIVR_WORD_ZERO;
         ack_r <= 1'b0;
         hit_r <= 1'b0;
         vme_r <= `PCIVR_WORD_ZERO;
         win_r <= 1'b0;
         blt_r <= 1'b0;
         mblt_r <= 1'b0;
         pw_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ack_r <= i_reg_rd | i_reg_wr;
         hit_r <= dec_hit;
         vme_r <= dec_vme;
         win_r <= win_nxt;
         blt_r <= blt_nxt;
         mblt_r <= mblt_nxt;
         pw_r <= pw_nxt;
      end
   end
   assign o_reg_rdata = rdata_r;
   assign o_reg_ack = ack_r;
   assign o_regs_open = open_r;
   assign o_win_hit = win_r;
   assign o_image_hit = hit_r;
   assign o_vme_addr = vme_r;
   assign o_vme_width = vdw_r;
   assign o_vme_space = vas_r;
   assign o_block_xfer = blt_r;
   assign o_mblt_allowed = mblt_r;
   assign o_posted_write = pw_r;
   assign o_am_program = pgm_r;
   assign o_am_super = super_r;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic rd_q;
   logic [11:0] ra_q;
   logic [31:0] sum_q;
   always_ff @(posedge i_clock) begin
      rd_q <= i_reg_rd & dev_ok;
      ra_q <= waddr;
      sum_q <= {20'(i_pci_addr[31:12] + lto_r), i_pci_addr[11:0]};
   end
   sequence s_line_wr;
      i_reg_wr && !s_load && waddr == `PCIVR_OFF_MISC1 && i_reg_be[0];
   endsequence
   sequence s_locked_ctl_wr;
      i_reg_wr && !s_load && !open_r && waddr == `PCIVR_OFF_CTL;
   endsequence
   AST_ALIGN_ZERO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      rd_q && (ra_q == `PCIVR_OFF_BS0 || ra_q == `PCIVR_OFF_BS1) |-> o_reg_rdata[11:1] == 11'h000)
      else $error("base low bits not zero");
   AST_SPACE_INVERT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      rd_q && ra_q == `PCIVR_OFF_BS1 |-> o_reg_rdata[0] == !$past(space0_r))
      else $error("second space bit not inverted");
   AST_STRAP_SPACE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_load |=> space0_r == !$past(s_pins[0]))
      else $error("strap space wrong");
   AST_FIXED_BYTES: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      rd_q && ra_q == `PCIVR_OFF_MISC1 |-> o_reg_rdata[31:8] == 24'h000301)
      else $error("fixed config bytes wrong");
   AST_LINE_STORE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_line_wr |=> int_line_r == $past(i_reg_wdata[7:0]))
      else $error("interrupt line not stored");
   AST_LOCKED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_locked_ctl_wr |=> $stable(vdw_r) && $stable(en_r) && $stable(las_r))
      else $error("image written while locked");
   AST_BLOCK_EFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_block_xfer |-> $past(vct_r) && $past(vdw_r) != pcivr_pkg::PCIVR_W64 &&
                       ($past(vas_r) == pcivr_pkg::PCIVR_A24 || $past(vas_r) == pcivr_pkg::PCIVR_A32))
      else $error("block transfer enabled wrongly");
   AST_MBLT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ##1 ($past(vdw_r) == pcivr_pkg::PCIVR_W64 && $past(vas_r) == pcivr_pkg::PCIVR_A32) |-> o_mblt_allowed)
      else $error("multiplexed block not allowed");
   AST_COUPLED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_posted_write |-> !$past(las_r) && $past(posted_write_enable_r))
      else $error("posted write in io space");
   AST_HIT_RANGE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_image_hit |-> $past(i_pci_addr[31:12]) >= $past(lbs_r) && $past(en_r))
      else $error("image hit below base");
   AST_TRANSLATE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_image_hit |-> o_vme_addr == sum_q)
      else $error("vme address not translated");
endmodule : pcivr_regs

/* File: core/pcivr_params.svh */
// pcivr_params.svh: offsets, field positions, reset values of the register bank
// assumes: included by bare name wherever these constants are used
`ifndef PCIVR_PARAMS_SVH
`define PCIVR_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define PCIVR_OFF_BS0 12'h010
`define PCIVR_OFF_BS1 12'h014
`define PCIVR_OFF_MISC1 12'h03C
`define PCIVR_OFF_CTL 12'h100
`define PCIVR_OFF_LBS 12'h104
`define PCIVR_OFF_LBD 12'h108
`define PCIVR_OFF_LTO 12'h10C
`define PCIVR_DEV_FIRST 12'h100

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PCIVR_BASE_LSB 12
`define PCIVR_SPACE_BIT 0
`define PCIVR_CTL_EN 31
`define PCIVR_CTL_POSTED_WRITE_ENABLE 30
`define PCIVR_CTL_VDW_LSB 22
`define PCIVR_CTL_VAS_LSB 16
`define PCIVR_CTL_PGM 14
`define PCIVR_CTL_SUPER 12
`define PCIVR_CTL_VCT 8
`define PCIVR_CTL_LAS 0
`define PCIVR_TOP_LSB 16

// ---------------------------------------------------------------
// fixed and reset values
// ---------------------------------------------------------------
`define PCIVR_MAX_LATENCY_FIELD 8'h00
`define PCIVR_MIN_GNT 8'h03
`define PCIVR_INT_PIN 8'h01
`define PCIVR_INT_LINE_RST 8'h00
`define PCIVR_BASE_RST 20'h00000
`define PCIVR_MID_RST 16'h0000
`define PCIVR_WORD_ZERO 32'h00000000

`endif

/* File: core/pcivr_pkg.sv */
// pcivr_pkg.sv: types of the register bank
// assumes: compiled before all design modules
package pcivr_pkg;

   // ---------------------------------------------------------------
   // vme data width and address space codes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PCIVR_W8 = 2'h0,
      PCIVR_W16 = 2'h1,
      PCIVR_W32 = 2'h2,
      PCIVR_W64 = 2'h3
   } pcivr_width_e;

   typedef enum logic [2:0] {
      PCIVR_A16 = 3'h0,
      PCIVR_A24 = 3'h1,
      PCIVR_A32 = 3'h2,
      PCIVR_CRCSR = 3'h5,
      PCIVR_USER1 = 3'h6,
      PCIVR_USER2 = 3'h7
   } pcivr_space_e;

   typedef logic [19:0] pcivr_page_t;

endpackage : pcivr_pkg

/* File: core/pcivr_strap.sv */
// pcivr_strap.sv: synchronises power-up strap pins and marks their capture
// assumes: reset held at least 3 clock edges so the synchronisers settle
`timescale 1ns/10ps
module pcivr_strap (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [9:0] i_pins,
   output logic o_load,
   output logic [9:0] o_pins
);

   // ---------------------------------------------------------------
   // two-flop synchroniser and capture pulse
   // ---------------------------------------------------------------
   logic [9:0] meta_r;
   logic [9:0] sync_r;
   logic done_r;
   logic done_nxt;
   logic load_r;
   logic load_nxt;

   always_comb begin
      done_nxt = i_rst_n;
      load_nxt = i_rst_n & ~done_r;
   end

   always_ff @(posedge i_clock) begin
      meta_r <= i_pins;
      sync_r <= meta_r;
      if (!i_rst_n) begin
         done_r <= 1'b0;
         load_r <= 1'b0;
      end else begin
         done_r <= done_nxt;
         load_r <= load_nxt;
      end
   end

   assign o_load = load_r;
   assign o_pins = sync_r;

endmodule : pcivr_strap

/* File: core/pcivr_img_dec.sv */
// pcivr_img_dec.sv: address window compare and translation of one target image
// assumes: inputs come from the same clock domain; result is registered by the user
`timescale 1ns/10ps
`include "pcivr_params.svh"
module pcivr_img_dec (
   input wire logic i_valid,
   input wire logic i_io,
   input wire logic [31:0] i_addr,
   input wire logic i_enable,
   input wire logic i_las,
   input wire pcivr_pkg::pcivr_page_t i_base,
   input wire pcivr_pkg::pcivr_page_t i_bound,
   input wire pcivr_pkg::pcivr_page_t i_offset,
   output logic o_hit,
   output logic [31:0] o_vme_addr
);

   // ---------------------------------------------------------------
   // decode and translate
   // ---------------------------------------------------------------
   pcivr_pkg::pcivr_page_t page;
   logic above;
   logic below;

   always_comb begin
      page = i_addr[31:12];
      above = (page >= i_base);
      below = (i_bound == `PCIVR_BASE_RST) | (page < i_bound);
      o_hit = i_valid & i_enable & (i_io == i_las) & above & below;
      o_vme_addr = {20'(page + i_offset), i_addr[11:0]};
   end

endmodule : pcivr_img_dec

/* File: verif/pcivr_host.sv */
// pcivr_host.sv: pci host model issuing config accesses
// assumes: one access at a time, driven 1 ns after the rising edge
`timescale 1ns/10ps
module pcivr_host (
   input wire logic i_clock,
   input wire logic i_ack,
   input wire logic [31:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [11:0] o_addr,
   output logic [3:0] o_be,
   output logic [31:0] o_wdata
);
   // ---------------------------------------------------------------
   // access task
   // ---------------------------------------------------------------
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 12'h000;
      o_be = 4'h0;
      o_wdata = 32'h00000000;
   end

   // one-cycle request, answer sampled with ack
   task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q, output logic k);
      @(posedge i_clock);
      #1;
      o_wr = w;
      o_rd = ~w;
      o_addr = a;
      o_be = be;
      o_wdata = d;
      @(posedge i_clock);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      k = i_ack;
      q = i_rdata;
      // released lines show the inverse of the last value
      o_addr = ~a;
      o_be = ~be;
      o_wdata = ~d;
   endtask : acc
endmodule : pcivr_host

/* File: verif/tb.sv */
// tb.sv: self-checking bench of the register bank
// assumes: host model drives the config port, bench drives straps and pci address
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic va1 = 1'b0;
   logic strap_en = 1'b1;
   logic strap_las = 1'b0;
   logic [2:0] strap_vas = 3'h2;
   logic [3:0] strap_top = 4'h0;
   logic wr, rd, ack, open, win, hit, blk, mblt, pw, amp, ams;
   logic [11:0] addr;
   logic [3:0] be;
   logic [31:0] wd, rdat, vaddr, q;
   logic k;
   logic pv = 1'b0;
   logic pio = 1'b0;
   logic [31:0] pa = 32'h00000000;
   pcivr_pkg::pcivr_width_e wid;
   pcivr_pkg::pcivr_space_e spc;
   int miscompares = 0;
   int n_compared = 0;

   initial begin
      forever #50 clk = ~clk;
   end

   pcivr_host host (.i_clock(clk), .i_ack(ack), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_be(be), .o_wdata(wd));

   pcivr_regs dut (.i_clock(clk), .i_rst_n(rst_n), .i_strap_va1(va1), .i_strap_img_en(strap_en),
      .i_strap_img_las(strap_las), .i_strap_img_vas(strap_vas), .i_strap_img_top(strap_top),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_be(be), .i_reg_wdata(wd),
      .i_pci_valid(pv), .i_pci_io(pio), .i_pci_addr(pa), .o_reg_rdata(rdat), .o_reg_ack(ack),
      .o_regs_open(open), .o_win_hit(win), .o_image_hit(hit), .o_vme_addr(vaddr),
      .o_vme_width(wid), .o_vme_space(spc), .o_block_xfer(blk), .o_mblt_allowed(mblt),
      .o_posted_write(pw), .o_am_program(amp), .o_am_super(ams));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask : chk

   task automatic wrr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      host.acc(1'b1, a, b, d, q, k);
      chk("ack", 32'h1, k);
   endtask : wrr

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      host.acc(1'b0, a, 4'h0, 32'h00000000, q, k);
      chk("ack", 32'h1, k);
      chk("rdata", e, q);
   endtask : rdc

   task automatic dec(input logic io, input logic [31:0] a, input logic eh,
                      input logic [31:0] ev, input logic ew);
      @(posedge clk);
      #1;
      pv = 1'b1;
      pio = io;
      pa = a;
      @(posedge clk);
      #1;
      chk("image_hit", eh, hit);
      if (eh) begin
         chk("vme_addr", ev, vaddr);
      end
      chk("win_hit", ew, win);
      pv = 1'b0;
      pa = ~a;
   endtask : dec

   task automatic summarize();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset(input logic v);
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      va1 = v;
      strap_en = ~v;
      strap_las = v;
      strap_vas = v ? 3'h5 : 3'h2;
      strap_top = v ? 4'hA : 4'h0;
      repeat (3) @(posedge clk);
      #1;
      chk("width_rst", 32'h2, wid);
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      rdc(12'h010, {31'h0, ~v});
      rdc(12'h014, {31'h0, v});
      rdc(12'h100, 32'h00000000);
      chk("open", 32'h0, open);
      $display("test reset done");
   endtask : t_reset

   task automatic t_base();
      wrr(12'h100, 4'hF, 32'hFFFFFFFF);
      wrr(12'h010, 4'hF, 32'hFFFFFFFF);
      rdc(12'h010, 32'hFFFFF001);
      chk("open", 32'h1, open);
      rdc(12'h100, 32'h80820000);
      wrr(12'h010, 4'h8, 32'h12345678);
      rdc(12'h010, 32'h12FFF001);
      wrr(12'h014, 4'hF, 32'h00005FFF);
      rdc(12'h014, 32'h00005000);
      wrr(12'h03C, 4'hF, 32'hFFFFFFFF);
      rdc(12'h03C, 32'h000301FF);
      wrr(12'h200, 4'hF, 32'hFFFFFFFF);
      rdc(12'h200, 32'h00000000);
      $display("test base done");
   endtask : t_base

   task automatic t_ctl();
      logic [1:0] w;
      logic [2:0] v;
      logic p, l, nar;
      logic [31:0] d;
      for (int i = 0; i < 32; i++) begin
         w = i[1:0];
         v = i[4:2];
         p = i[0] ^ i[2];
         l = i[1] ^ i[3];
         d = 32'h80000100 | (w << 22) | (v << 16) | (p << 30) | (p << 14) | (l << 12) | l;
         wrr(12'h100, 4'hF, d);
         rdc(12'h100, d);
         @(posedge clk);
         #1;
         nar = (v == 3'h1) || (v == 3'h2);
         chk("width", w, wid);
         chk("space", v, spc);
         chk("block", nar && (w != 2'h3), blk);
         chk("mblt", nar && (w == 2'h3), mblt);
         chk("posted", p & ~l, pw);
         chk("am_prog", p, amp);
         chk("am_super", l, ams);
      end
      wrr(12'h100, 4'hF, 32'h80410000);
      @(posedge clk);
      #1;
      chk("block_off", 32'h0, blk);
      $display("test ctl done");
   endtask : t_ctl

   task automatic t_dec();
      wrr(12'h100, 4'hF, 32'h80820000);
      wrr(12'h104, 4'hF, 32'h00100000);
      wrr(12'h108, 4'hF, 32'h00200000);
      wrr(12'h10C, 4'hF, 32'h00010000);
      dec(1'b0, 32'h00100ABC, 1'b1, 32'h00110ABC, 1'b0);
      dec(1'b0, 32'h001FFFFC, 1'b1, 32'h0020FFFC, 1'b0);
      dec(1'b0, 32'h00200000, 1'b0, 32'h0, 1'b0);
      dec(1'b0, 32'h000FF000, 1'b0, 32'h0, 1'b0);
      dec(1'b1, 32'h00100000, 1'b0, 32'h0, 1'b0);
      dec(1'b1, 32'h12FFF010, 1'b0, 32'h0, 1'b1);
      dec(1'b0, 32'h00005004, 1'b0, 32'h0, 1'b1);
      wrr(12'h108, 4'hF, 32'h00000000);
      dec(1'b0, 32'hF0000000, 1'b1, 32'hF0010000, 1'b0);
      wrr(12'h10C, 4'hF, 32'hFFF00000);
      dec(1'b0, 32'h00100000, 1'b1, 32'h00000000, 1'b0);
      wrr(12'h100, 4'hF, 32'h00820000);
      dec(1'b0, 32'h00100ABC, 1'b0, 32'h0, 1'b0);
      $display("test decode done");
   endtask : t_dec

   // strap reset values of image 0, seen once the base unlocks them
   task automatic t_strap();
      wrr(12'h010, 4'hF, 32'h00000000);
      rdc(12'h100, 32'h00850001);
      rdc(12'h104, 32'hA0000000);
      rdc(12'h108, 32'hA0000000);
      rdc(12'h10C, 32'h00000000);
      chk("space_strap", 32'h5, spc);
      $display("test strap done");
   endtask : t_strap

   initial begin
      t_reset(1'b0);
      t_base();
      t_ctl();
      t_dec();
      t_reset(1'b1);
      t_strap();
      summarize();
   end
endmodule : tb
